// *** twb_cfg.svh ***
`ifndef TWB_CFG_SVH
`define TWB_CFG_SVH
// What this block does
// - Data edge during clock high is condition
// - Data falling, clock high, means start
// - Data rising, clock high, ends transfer
// - Stop after a read enters standby unless internal work is busy
// - Every address and data item is eight bits
// - Ack drives data low on ninth clock
// - Standby at power-up and after finished stop
// - Sample on clock rise, drive after fall
// - Ack address only on match, else standby

// Word width and index of its last bit
`define TWB_WORD_W    8
`define TWB_WORD_LAST 3'h7
// Device address width, excluding direction bit
`define TWB_ADDR_W    7
// Level that acknowledges a word
`define TWB_ACK_LVL   1'b0
// Direction bit value selecting a read
`define TWB_RW_READ   1'b1
// Ninth-clock phases held in the bit counter
`define TWB_PH_WAIT   3'h0
`define TWB_PH_DONE   3'h1
// Reset values: lines idle high, toggle and bit low
`define TWB_LINE_IDLE 4'hc
`define TWB_SDA_DRIVE 1'b0
`endif

// *** twb_ctl.sv ***
`timescale 1ns/1ps
// Behavioural bus controller on the far side of the link
module twb_ctl (
  output logic      o_scl,     // Serial clock, rests high outside frames
  output logic      o_sda_low, // High while we pull data low
  input  wire logic i_sda      // Resolved data line
);
  // Quarter phase in ns; odd so the edges drift against the system clock
  localparam int QTR = 61;
  initial begin
    o_scl     = 1'b1;
    o_sda_low = 1'b0;
  end
  // data moves mid-low, sampled at end of high
  task automatic bit_io(input logic b, output logic r);
    #QTR o_sda_low = ~b;
    #QTR o_scl = 1'b1;
    #(2*QTR) r = i_sda;
    o_scl = 1'b0;
  endtask
  // start: data falls while clock high
  task automatic start_c();
    #QTR o_sda_low = 1'b0;
    #QTR o_scl = 1'b1;
    #QTR o_sda_low = 1'b1;
    #QTR o_scl = 1'b0;
  endtask
  // stop: data rises while clock high
  task automatic stop_c();
    #QTR o_sda_low = 1'b1;
    #QTR o_scl = 1'b1;
    #QTR o_sda_low = 1'b0;
    #QTR;
  endtask
  // eight bits MSB first, ninth bit released for the answer
  task automatic put_word(input logic [7:0] w, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(w[i], r);
    bit_io(1'b1, ack);
  endtask
  // eight bits in, then our answer m on the ninth clock
  task automatic get_word(input logic m, output logic [7:0] w);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, w[i]);
    bit_io(m, r);
  endtask
  // clock at most nine times until data is high, then start
  task automatic recover(output int n);
    logic r;
    n = 0;
    do begin
      bit_io(1'b1, r);
      n++;
    end while (r !== 1'b1 && n < 9);
    start_c();
  endtask
endmodule

// *** twb_link_cap.sv ***
`timescale 1ns/1ps
module twb_link_cap (
  input  wire logic               i_clk_link, // Serial clock as a clock
  input  wire logic               i_rst_link, // Async reset, active high
  input  wire logic               i_sda,      // Data pin
  output twb_pkg::twb_cap_s       o_cap       // Bit and event toggle
);
  import twb_pkg::*;

  twb_cap_s q; // Registered capture
  twb_cap_s d; // Next capture

  // Catch the bit and flip the toggle each rise
  always_comb begin
    d       = q;
    d.bit_v = i_sda;
    d.tog   = ~q.tog;
  end

  // Clock may stand still, so reset cannot wait for it
  always_ff @(posedge i_clk_link or posedge i_rst_link) begin
    if (i_rst_link) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign o_cap = q;
endmodule

// *** twb_pkg.sv ***
`include "twb_cfg.svh"
package twb_pkg;
  // One-hot controller states
  typedef enum logic [7:0] {
    TWB_IDLE = 8'h01, // Standby, lines released
    TWB_ADDR = 8'h02, // Shifting in the address word
    TWB_RX   = 8'h04, // Shifting in a data word
    TWB_ACK  = 8'h08, // Our acknowledge on the ninth clock
    TWB_TX   = 8'h10, // Shifting out a data word
    TWB_MACK = 8'h20, // Controller acknowledge of our word
    TWB_HOLD = 8'h40, // Released, waiting for a condition
    TWB_WAIT = 8'h80  // Stopped, internal work still busy
  } twb_state_e;

  // Pin and crossing samples that travel together
  typedef struct packed {
    logic scl;   // Clock pin level
    logic sda;   // Data pin level
    logic tog;   // Flips on each clock rise
    logic bit_v; // Data bit caught at that rise
  } twb_line_s;

  // Two synchroniser stages
  typedef struct packed {
    twb_line_s s1;
    twb_line_s s2;
  } twb_sync_s;

  // Link-domain capture state
  typedef struct packed {
    logic bit_v;
    logic tog;
  } twb_cap_s;

  // Received byte strobe with its data
  typedef struct packed {
    logic                    valid;
    logic [`TWB_WORD_W-1:0]  data;
  } twb_wr_s;

  // Whole state of the main controller
  typedef struct packed {
    twb_state_e             st;
    logic [2:0]             cnt;
    logic [`TWB_WORD_W-1:0] sh;
    logic                   rw;
    logic                   oe;
    logic                   sda_o;
    logic                   standby;
    logic                   start_p;
    logic                   stop_p;
    logic                   rd_take;
    twb_wr_s                wr;
    twb_line_s              prev;
    logic                   tog_old;
    logic                   rst_link;
  } twb_main_s;
endpackage

// *** twb_sync.sv ***
`timescale 1ns/1ps
module twb_sync (
  input  wire logic                i_clk_sys, // System clock
  input  wire logic                i_reset,   // Sync reset, active high
  input  wire twb_pkg::twb_line_s  i_async,   // Unsynchronised samples
  output twb_pkg::twb_line_s       o_sync     // Two-stage synchronised
);
  import twb_pkg::*;

  twb_sync_s q; // Registered stages
  twb_sync_s d; // Next stages

  // First stage feeds only the second one
  always_comb begin
    d    = q;
    d.s1 = i_async;
    d.s2 = q.s1;
  end

  // Reset to idle lines so no false condition appears
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      q <= {`TWB_LINE_IDLE, `TWB_LINE_IDLE};
    end else begin
      q <= d;
    end
  end

  assign o_sync = q.s2;
endmodule

// *** twb_top.sv ***
`timescale 1ns/1ps
`include "twb_cfg.svh"
module twb_top (
  input  wire logic                    i_clk_sys,  // System clock
  input  wire logic                    i_reset,    // Sync reset, active high
  input  wire logic                    i_clk_scl,  // Serial clock as clock
  input  wire logic                    i_scl,      // Serial clock pin level
  input  wire logic                    i_sda,      // Data pin level
  output logic                         o_sda_o,    // Data drive value
  output logic                         o_sda_oe,   // Data drive enable
  input  wire logic [`TWB_ADDR_W-1:0]  i_dev_addr, // Our device address
  input  wire logic                    i_busy,     // Internal work running
  input  wire logic [`TWB_WORD_W-1:0]  i_rd_byte,  // Next byte to send
  output logic                         o_rd_take,  // Read byte taken
  output twb_pkg::twb_wr_s             o_wr,       // Received byte
  output logic                         o_rw,       // Direction of access
  output logic                         o_start,    // Start seen
  output logic                         o_stop,     // Stop seen
  output logic                         o_standby   // Low-power standby
);
  import twb_pkg::*;

  twb_main_s q;        // Registered state
  twb_main_s d;        // Next state
  twb_line_s ln;       // Synchronised lines and capture
  twb_cap_s  cap;      // Link-domain capture
  logic      ev_start; // Start condition
  logic      ev_stop;  // Stop condition
  logic      ev_fall;  // Clock falling edge
  logic      ev_bit;   // New bit captured
  logic      addr_hit; // Address word matches
  logic      load;     // Fetch next read byte

  // Bits are caught on the serial clock itself
  twb_link_cap twb_link_cap_i (
    .i_clk_link (i_clk_scl),
    .i_rst_link (q.rst_link),
    .i_sda      (i_sda),
    .o_cap      (cap)
  );

  // Pins and capture toggle enter this domain here
  twb_sync twb_sync_i (
    .i_clk_sys (i_clk_sys),
    .i_reset   (i_reset),
    .i_async   ({i_scl, i_sda, cap.tog, cap.bit_v}),
    .o_sync    (ln)
  );

  // Bus event decode from synchronised levels
  always_comb begin
    ev_start = ln.scl & q.prev.scl & q.prev.sda & ~ln.sda;
    ev_stop  = ln.scl & q.prev.scl & ~q.prev.sda & ln.sda;
    ev_fall  = q.prev.scl & ~ln.scl;
    // bit taken at rise
    // Event one cycle late so the bit has settled
    ev_bit   = q.prev.tog ^ q.tog_old;
    // address compare
    // Busy device stays silent for acknowledge polling
    addr_hit = (q.sh[`TWB_ADDR_W-1:0] == i_dev_addr) & ~i_busy;
  end

  // Controller next state
  always_comb begin
    d          = q;
    load       = 1'b0;
    d.prev     = ln;
    d.tog_old  = q.prev.tog;
    d.start_p  = 1'b0;
    d.stop_p   = 1'b0;
    d.rd_take  = 1'b0;
    d.wr.valid = 1'b0;
    d.rst_link = 1'b0;
    d.sda_o    = `TWB_SDA_DRIVE;
    if (ev_start) begin
      d.st      = TWB_ADDR;
      d.cnt     = 3'h0;
      d.oe      = 1'b0;
      d.start_p = 1'b1;
    end else if (ev_stop) begin
      d.st     = i_busy ? TWB_WAIT : TWB_IDLE;
      d.cnt    = 3'h0;
      d.oe     = 1'b0;
      d.stop_p = 1'b1;
    end else begin
      case (q.st)
        TWB_IDLE: begin
          d.oe = 1'b0;
        end
        TWB_HOLD: begin
          d.oe = 1'b0;
        end
        // Standby only after internal work ends
        TWB_WAIT: begin
          if (!i_busy) begin
            d.st = TWB_IDLE;
          end
        end
        TWB_ADDR: begin
          if (ev_bit) begin
            d.sh  = {q.sh[`TWB_WORD_W-2:0], ln.bit_v};
            d.cnt = q.cnt + 3'h1;
            if (q.cnt == `TWB_WORD_LAST) begin
              d.cnt = 3'h0;
              d.rw  = ln.bit_v;
              d.st  = addr_hit ? TWB_ACK : TWB_IDLE;
            end
          end
        end
        TWB_RX: begin
          if (ev_bit) begin
            d.sh  = {q.sh[`TWB_WORD_W-2:0], ln.bit_v};
            d.cnt = q.cnt + 3'h1;
            if (q.cnt == `TWB_WORD_LAST) begin
              d.cnt      = 3'h0;
              d.wr.valid = 1'b1;
              d.wr.data  = {q.sh[`TWB_WORD_W-2:0], ln.bit_v};
              d.st       = TWB_ACK;
            end
          end
        end
        TWB_ACK: begin
          if (ev_fall && q.cnt == `TWB_PH_WAIT) begin
            d.oe = 1'b1;
          end else if (ev_bit) begin
            d.cnt = `TWB_PH_DONE;
          end else if (ev_fall && q.cnt == `TWB_PH_DONE) begin
            d.oe  = 1'b0;
            d.cnt = 3'h0;
            if (q.rw == `TWB_RW_READ) begin
              load = 1'b1;
            end else begin
              d.st = TWB_RX;
            end
          end
        end
        TWB_TX: begin
          if (ev_bit) begin
            d.cnt = q.cnt + 3'h1;
            if (q.cnt == `TWB_WORD_LAST) begin
              d.cnt = 3'h0;
              d.st  = TWB_MACK;
            end
          end else if (ev_fall) begin
            d.sh = {q.sh[`TWB_WORD_W-2:0], 1'b0};
            d.oe = ~q.sh[`TWB_WORD_W-2];
          end
        end
        // Controller acknowledge keeps a read going
        TWB_MACK: begin
          if (ev_fall && q.cnt == `TWB_PH_WAIT) begin
            d.oe = 1'b0;
          end else if (ev_bit) begin
            if (ln.bit_v == `TWB_ACK_LVL) begin
              d.cnt = `TWB_PH_DONE;
            end else begin
              d.st = TWB_HOLD;
            end
          end else if (ev_fall && q.cnt == `TWB_PH_DONE) begin
            load = 1'b1;
          end
        end
        default: begin
          d.st = TWB_IDLE;
          d.oe = 1'b0;
        end
      endcase
    end
    // Fetch and drive the first bit of a read byte
    if (load) begin
      d.st      = TWB_TX;
      d.cnt     = 3'h0;
      d.sh      = i_rd_byte;
      d.oe      = ~i_rd_byte[`TWB_WORD_W-1];
      d.rd_take = 1'b1;
    end
    d.standby = (d.st == TWB_IDLE);
  end

  // State register; link reset held one cycle past ours
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      q          <= '0;
      q.st       <= TWB_IDLE;
      q.sda_o    <= `TWB_SDA_DRIVE;
      q.standby  <= 1'b1;
      q.prev     <= `TWB_LINE_IDLE;
      q.rst_link <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // Outputs straight from the state register
  assign o_sda_o   = q.sda_o;
  assign o_sda_oe  = q.oe;
  assign o_rd_take = q.rd_take;
  assign o_wr      = q.wr;
  assign o_rw      = q.rw;
  assign o_start   = q.start_p;
  assign o_stop    = q.stop_p;
  assign o_standby = q.standby;

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_reset);

  // Start always opens a fresh address word
  start_addr_a: assert property (
    ev_start |=> q.st == TWB_ADDR && o_start && q.cnt == 3'h0)
    else $error("start did not open address word");

  // Mid-word start drops the partial word
  restart_a: assert property (
    ev_start && q.st == TWB_RX |=> !o_wr.valid ##1 q.st == TWB_ADDR)
    else $error("restart kept partial word");

  // Stop ends the transfer and releases the line
  stop_end_a: assert property (
    ev_stop && !ev_start |=> o_stop && !o_sda_oe
      && (q.st == TWB_IDLE || q.st == TWB_WAIT))
    else $error("stop did not end transfer");

  // Conditions never count as data bits
  cond_nobit_a: assert property (
    (ev_start || ev_stop) |=> q.cnt == 3'h0 && !o_wr.valid)
    else $error("condition counted as data");

  // Stop after a read goes to standby when not busy
  read_stop_a: assert property (
    q.st == TWB_HOLD && ev_stop && !i_busy |=> o_standby)
    else $error("no standby after read stop");

  // Standby once internal work finishes
  wait_idle_a: assert property (
    q.st == TWB_WAIT && !i_busy && !ev_start && !ev_stop
      |=> o_standby ##1 o_standby || $past(ev_start))
    else $error("no standby after busy ended");

  // Eighth data bit yields one byte strobe
  word_len_a: assert property (
    q.st == TWB_RX && ev_bit && q.cnt == `TWB_WORD_LAST
      && !ev_start && !ev_stop |=> o_wr.valid ##1 !o_wr.valid)
    else $error("byte strobe not after eight bits");

  // Ack drives low from the fall before the ninth clock
  ack_drive_a: assert property (
    q.st == TWB_ACK && ev_fall && q.cnt == `TWB_PH_WAIT
      && !ev_start && !ev_stop |=> o_sda_oe && !o_sda_o)
    else $error("ack not driven low");

  // Mismatched address gets no ack and returns to standby
  addr_miss_a: assert property (
    q.st == TWB_ADDR && ev_bit && q.cnt == `TWB_WORD_LAST
      && !addr_hit && !ev_start && !ev_stop
      |=> q.st == TWB_IDLE && o_standby ##1 !o_sda_oe)
    else $error("mismatch not ignored");

  // Drive changes only at a fall or a condition
  drive_fall_a: assert property (
    $changed(o_sda_oe) |-> $past(ev_fall || ev_start || ev_stop))
    else $error("drive changed outside clock low");

  // Line driven only low and only while answering
  release_a: assert property (
    o_sda_oe |-> !o_sda_o
      && (q.st == TWB_ACK || q.st == TWB_TX || q.st == TWB_MACK))
    else $error("data line not released");

  // Ack low stands through the ninth high phase
  ack_hold_a: assert property (
    q.st == TWB_ACK && o_sda_oe && !ev_fall && !ev_start && !ev_stop |=> o_sda_oe)
    else $error("ack dropped before clock fall");

  // Read bit holds until the next clock fall
  tx_hold_a: assert property (
    q.st == TWB_TX && !ev_fall && !ev_start && !ev_stop |=> $stable(o_sda_oe))
    else $error("read bit changed while clock high");

  // Standby never drives the data line
  stby_rel_a: assert property (
    o_standby |-> !o_sda_oe && q.st == TWB_IDLE)
    else $error("standby with line driven");

  // Main scenarios
  write_byte_c: cover property (o_wr.valid ##[1:400] q.st == TWB_ACK && o_sda_oe);
  read_byte_c:  cover property (o_rd_take ##[1:1000] q.st == TWB_MACK);
  addr_miss_c:  cover property (q.st == TWB_ADDR ##1 q.st == TWB_IDLE);
  busy_wait_c:  cover property (q.st == TWB_WAIT ##[1:1000] q.st == TWB_IDLE);
endmodule

// *** twb_top_tb.sv ***
`timescale 1ns/1ps
module twb_top_tb;
  import twb_pkg::*;
  // One ordinary transfer: inputs and expected ninth bit
  typedef struct packed {
    logic [6:0] a;   // Address sent
    logic       bsy; // Internal work flag
    logic [7:0] d;   // Data byte
    logic       ack; // Expected address answer
  } twb_row_s;
  twb_row_s   rows [6] = '{{7'h53, 1'b0, 8'h00, 1'b0}, {7'h53, 1'b0, 8'hff, 1'b0},
                           {7'h52, 1'b0, 8'h00, 1'b1}, {7'h13, 1'b0, 8'h00, 1'b1},
                           {7'h53, 1'b1, 8'h5a, 1'b1}, {7'h53, 1'b0, 8'ha5, 1'b0}};
  logic       clk;     // System clock
  logic       rst;     // Sync reset
  logic       busy;    // Internal work running
  logic [7:0] rd_byte; // Byte offered for reading
  logic       scl;     // Serial clock from the controller
  logic       sda_low; // Controller pull-down
  wire        sda;     // Data line with pull-up
  logic       sda_o, sda_oe, take, rw, st_p, sp_p, stby;
  twb_wr_s    wr;      // Received byte strobe
  int         errors, tests_run, n_wr, n_st, n_sp, n_tk, n0, n;
  logic [7:0] wr_data, w;
  logic       ack;

  // Open drain: low if either party pulls, else the pull-up wins
  assign sda = !(sda_low || (sda_oe && !sda_o));

  twb_ctl twb_ctl_i (.o_scl(scl), .o_sda_low(sda_low), .i_sda(sda));
  twb_top twb_top_i (.i_clk_sys(clk), .i_reset(rst), .i_clk_scl(scl), .i_scl(scl),
    .i_sda(sda), .o_sda_o(sda_o), .o_sda_oe(sda_oe), .i_dev_addr(7'h53), .i_busy(busy),
    .i_rd_byte(rd_byte), .o_rd_take(take), .o_wr(wr), .o_rw(rw), .o_start(st_p),
    .o_stop(sp_p), .o_standby(stby));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Count pulses away from the launching edge; keep the last received byte
  always @(negedge clk) begin
    if (wr.valid === 1'b1) begin
      n_wr++;
      wr_data = wr.data;
    end
    if (st_p === 1'b1) n_st++;
    if (sp_p === 1'b1) n_sp++;
    if (take === 1'b1) n_tk++;
  end
  // Offer the next read byte once one is taken
  always @(negedge clk) if (take === 1'b1) rd_byte <= rd_byte + 8'h11;

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t %s got %h want %h", $time, what, got, exp);
    end
  endtask
  // Conditions need a few system cycles to cross over
  task automatic settle();
    repeat (6) @(negedge clk);
  endtask
  task automatic stop_test();
    if (errors == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // Hang guard
  initial begin
    #600us;
    errors++;
    stop_test();
  end

  initial begin
    rst = 1'b1;
    busy = 1'b0;
    rd_byte = 8'h3c;
    repeat (3) @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    foreach (rows[k]) begin
      @(negedge clk) busy = rows[k].bsy;
      n0 = n_st;
      n = n_sp;
      twb_ctl_i.start_c();
      twb_ctl_i.put_word({rows[k].a, 1'b0}, ack);
      chk(ack, rows[k].ack, "addr ack");
      chk(stby, rows[k].ack, "standby after addr");
      if (ack === 1'b0) begin
        twb_ctl_i.put_word(rows[k].d, ack);
        chk(ack, 1'b0, "data ack");
        chk(wr_data, rows[k].d, "data");
      end
      @(negedge clk) busy = 1'b0;
      twb_ctl_i.stop_c();
      settle();
      chk(8'(n_st - n0), 8'h01, "start count");
      chk(8'(n_sp - n), 8'h01, "stop count");
      chk(stby, 1'b1, "standby after stop");
    end
    // Read two bytes, refuse the second
    n0 = n_tk;
    twb_ctl_i.start_c();
    twb_ctl_i.put_word({7'h53, 1'b1}, ack);
    chk(ack, 1'b0, "read addr ack");
    twb_ctl_i.get_word(1'b0, w);
    chk(w, 8'h3c, "read byte 0");
    twb_ctl_i.get_word(1'b1, w);
    chk(w, 8'h4d, "read byte 1");
    twb_ctl_i.stop_c();
    settle();
    chk(rw, 1'b1, "direction");
    chk(8'(n_tk - n0), 8'h02, "bytes taken");
    chk(stby, 1'b1, "standby after read");
    // Start in mid-data-word drops the partial word
    twb_ctl_i.start_c();
    twb_ctl_i.put_word({7'h53, 1'b0}, ack);
    n = n_wr;
    for (int i = 0; i < 3; i++) twb_ctl_i.bit_io(i[0], w[0]);
    twb_ctl_i.start_c();
    twb_ctl_i.put_word({7'h53, 1'b0}, ack);
    chk(ack, 1'b0, "ack after restart");
    chk(8'(n_wr - n), 8'h00, "partial word kept");
    chk(rw, 1'b0, "write direction");
    twb_ctl_i.stop_c();
    // A word with no start in front is ignored; clock brought low first
    twb_ctl_i.bit_io(1'b1, w[0]);
    twb_ctl_i.put_word({7'h53, 1'b0}, ack);
    chk(ack, 1'b1, "no ack without start");
    twb_ctl_i.stop_c();
    // Busy after a write holds off standby
    twb_ctl_i.start_c();
    twb_ctl_i.put_word({7'h53, 1'b0}, ack);
    twb_ctl_i.put_word(8'h81, ack);
    @(negedge clk) busy = 1'b1;
    twb_ctl_i.stop_c();
    settle();
    chk(stby, 1'b0, "standby held while busy");
    busy = 1'b0;
    n = 0;
    while (stby !== 1'b1 && n < 20) begin
      @(negedge clk);
      n++;
    end
    chk(stby, 1'b1, "standby after busy");
    if (stby !== 1'b1) stop_test();
    // Abandon a read while the device drives, then recover
    twb_ctl_i.start_c();
    twb_ctl_i.put_word({7'h53, 1'b1}, ack);
    twb_ctl_i.bit_io(1'b1, w[0]);
    twb_ctl_i.bit_io(1'b1, w[0]);
    twb_ctl_i.recover(n);
    chk(8'(n), 8'h02, "recovery clocks");
    twb_ctl_i.put_word({7'h53, 1'b0}, ack);
    chk(ack, 1'b0, "ack after recovery");
    twb_ctl_i.stop_c();
    // Second reset in mid-run
    @(negedge clk) rst = 1'b1;
    repeat (3) @(negedge clk);
    chk(stby, 1'b1, "standby in reset");
    chk(sda_oe, 1'b0, "released in reset");
    chk(sda_o, 1'b0, "drive value in reset");
    rst = 1'b0;
    repeat (2) @(negedge clk);
    chk(stby, 1'b1, "standby after reset");
    chk(sda_oe, 1'b0, "released after reset");
    twb_ctl_i.start_c();
    twb_ctl_i.put_word({7'h53, 1'b0}, ack);
    chk(ack, 1'b0, "ack after reset");
    twb_ctl_i.stop_c();
    settle();
    stop_test();
  end
endmodule
